// *** hdl/hscr_pkg.sv ***
// Constants, field layout and carrier types of the host status/control bank
package hscr_pkg;

	// ----------------------------------------------------------------
	// Register offsets and banks
	// ----------------------------------------------------------------
	localparam logic [7:0] HSCR_OFS_HOUR_HIGH = 8'hFB;
	localparam logic [7:0] HSCR_OFS_HOUR_LOW  = 8'hFC;
	localparam logic [7:0] HSCR_OFS_READY     = 8'hFD;
	localparam logic [7:0] HSCR_OFS_USER_CTRL = 8'hFE;
	localparam logic [7:0] HSCR_OFS_RST_PULSE = 8'hFF;
	localparam logic       HSCR_BANK_A2       = 1'h0;
	localparam logic       HSCR_BANK_A6       = 1'h1;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HSCR_HOUR_CORRUPT_BIT = 7;
	localparam int HSCR_HOUR_SPLIT       = 8;
	localparam int HSCR_READY_LSB        = 3;
	localparam int HSCR_READY_N          = 5;
	localparam int HSCR_UC_MASK_BIT      = 6;
	localparam int HSCR_UC_FLAG_BIT      = 5;
	localparam int HSCR_UC_IE_BIT        = 4;
	localparam int HSCR_UC_PSEL_LSB      = 2;
	localparam int HSCR_UC_MSEL_LSB      = 0;
	localparam int HSCR_SEL_W            = 2;
	localparam int HSCR_PULSE_W          = 3;

	// ----------------------------------------------------------------
	// Reset and command values
	// ----------------------------------------------------------------
	localparam logic [7:0] HSCR_USER_CTRL_RST = 8'h20;
	localparam logic [4:0] HSCR_READY_RST     = 5'h00;
	localparam logic [2:0] HSCR_PULSE_RST     = 3'h0;
	localparam logic [2:0] HSCR_PULSE_FIRE    = 3'h7;
	localparam logic [1:0] HSCR_SEL_RSVD      = 2'h3;
	localparam logic [7:0] HSCR_RD_ZERO       = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int HSCR_CLK_MHZ       = 25;
	localparam int HSCR_PULSE_US      = 125;
	localparam int HSCR_CLR_DELAY_US  = 22500;
	localparam int HSCR_PULSE_CYC     = HSCR_PULSE_US * HSCR_CLK_MHZ;
	localparam int HSCR_CLR_DELAY_CYC = HSCR_CLR_DELAY_US * HSCR_CLK_MHZ;
	localparam int HSCR_CNT_W         = 20;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       bank;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hscr_req_t;

	typedef enum logic [1:0] {
		HSCR_IDLE,
		HSCR_DRIVE,
		HSCR_HOLD
	} hscr_pulse_st_t;

endpackage

// *** hdl/hscr_pulse_timer.sv ***
// Reset pulse sequencer for the open-drain general output
`timescale 1ns/100ps
module hscr_pulse_timer
	import hscr_pkg::*;
#(
	parameter int CLR_CYC = HSCR_CLR_DELAY_CYC
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic nrst,
	// Control
	input  wire logic fire,
	output logic      drive,
	output logic      clear_done
);

	hscr_pulse_st_t         st_r;
	hscr_pulse_st_t         st_nxt;
	logic [HSCR_CNT_W-1:0]  cnt_r;
	logic [HSCR_CNT_W-1:0]  cnt_nxt;
	wire                    pulse_end;
	wire                    hold_end;

	localparam logic [HSCR_CNT_W-1:0] PULSE_LAST =
		HSCR_CNT_W'(HSCR_PULSE_CYC - 1);
	localparam logic [HSCR_CNT_W-1:0] HOLD_LAST =
		HSCR_CNT_W'(CLR_CYC - 1);

	assign pulse_end = (st_r == HSCR_DRIVE) && (cnt_r == PULSE_LAST);
	assign hold_end  = (st_r == HSCR_HOLD) && (cnt_r == HOLD_LAST);
	assign drive      = (st_r == HSCR_DRIVE);
	assign clear_done = hold_end;

	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r + 1'b1;
		case (st_r)
			HSCR_IDLE: begin
				cnt_nxt = '0;
				if (fire)
					st_nxt = HSCR_DRIVE;
			end
			HSCR_DRIVE: begin
				if (pulse_end) begin
					st_nxt  = HSCR_HOLD;
					cnt_nxt = '0;
				end
			end
			HSCR_HOLD: begin
				if (hold_end) begin
					st_nxt  = HSCR_IDLE;
					cnt_nxt = '0;
				end
			end
			default: begin
				st_nxt  = HSCR_IDLE;
				cnt_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r  <= HSCR_IDLE;
			cnt_r <= '0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_pulse_width: assert property ( // [R18]
		($fell(drive)) |-> ($past(cnt_r) == PULSE_LAST))
		else $error("general output pulse has wrong width");
	chk_clear_after_hold: assert property ( // [R19]
		clear_done |-> ($past(st_r) == HSCR_HOLD) && !drive)
		else $error("field clear not preceded by hold time");

endmodule

// *** hdl/hscr_regs.sv ***
// Host status and control register bank with interrupt and reset pulse
`timescale 1ns/100ps

// Summary of operation
// R1: Hour-meter high byte bit 7 reports stored count corrupted.
// R2: Hour-meter high byte bits 6:0 carry upper seven count bits.
// R3: Finished conversion sets that parameter's data-ready flag.
// R4: Host read of a result register clears its data-ready flag.
// R5: Ready flags: temp 7, voltage 6, bias 5, tx 4, rx 3; 2:0 reserved.
// R6: Power setpoint select 3:2 picks setpoint 0, 1 or 2; 11 reserved.
// R7: Modulation select 1:0 picks register 0, 1 or 2; 11 reserved.
// R8: Interrupt line asserts only while global enable bit 4 is set.
// R9: Writing enable to 1 while interrupt asserted releases it at once.
// R10: Power-on flag bit 5 is set by every power-on reset.
// R11: With mask bit 6 set, power-on event raises host interrupt.
// R12: Reading user control clears power-on flag and releases interrupt.
// R13: Mask set while flag set asserts interrupt now, held until read.
// R14: Mask, enable and both selects are kept in non-volatile storage.
// R15: Host writes 0 to user control bit 7; its read value undefined.
// R16: Reset-pulse register: bits 7:3 read-only reserved, 2:0 read/write.
// R17: High byte's seven bits join low byte into 15-bit hour count.
// R18: In reset mode, writing 111 drives general output low ~125 us.
// R19: Field clears from 111 to 000 ~22.5 ms after pulse ends.
// R20: Without reset mode the reset-pulse field has no effect.
// R21: Interrupt output is enable AND mask AND flag, released otherwise or after an R9 enable write.
module hscr_regs
	import hscr_pkg::*;
#(
	parameter int CLR_CYC = HSCR_CLR_DELAY_CYC
) (
	// Clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	// Register access from the serial engine
	input  wire hscr_req_t                req,
	output logic [7:0]                    rd_data,
	// Conversion events
	input  wire logic [HSCR_READY_N-1:0]  conv_done,
	input  wire logic [HSCR_READY_N-1:0]  result_read,
	// Hour meter
	input  wire logic [14:0]              hour_count,
	input  wire logic                     hour_corrupt,
	// Non-volatile user control image
	input  wire logic [7:0]               nv_user_ctrl,
	output logic                          nv_wr,
	output logic [7:0]                    nv_wdata,
	// Configuration
	input  wire logic                     reset_mode,
	// Setpoint selection
	output logic [HSCR_SEL_W-1:0]         power_setpoint_select,
	output logic [HSCR_SEL_W-1:0]         modulation_setpoint_select,
	output logic [2:0]                    power_setpoint_onehot,
	output logic [2:0]                    modulation_setpoint_onehot,
	// Open-drain pins
	output logic                          int_n_o,
	output logic                          int_n_oe,
	output logic                          general_output_pin_o,
	output logic                          general_output_pin_oe
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] sel_decode(input logic [1:0] sel);
		logic [2:0] oh;
		oh = 3'h0;
		if (sel != HSCR_SEL_RSVD)
			oh[sel] = 1'b1;
		return oh;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [HSCR_READY_N-1:0] ready_r;
	logic [HSCR_READY_N-1:0] ready_nxt;
	logic                    mask_r;
	logic                    mask_nxt;
	logic                    flag_r;
	logic                    flag_nxt;
	logic                    ie_r;
	logic                    ie_nxt;
	logic [1:0]              psel_r;
	logic [1:0]              psel_nxt;
	logic [1:0]              msel_r;
	logic [1:0]              msel_nxt;
	logic                    squash_r;
	logic                    squash_nxt;
	logic [2:0]              pulse_r;
	logic [2:0]              pulse_nxt;
	logic                    nv_load_r;
	logic [7:0]              rd_data_r;
	logic [7:0]              rd_data_nxt;
	logic                    nv_wr_r;
	logic [7:0]              nv_wdata_r;
	logic [2:0]              poh_r;
	logic [2:0]              moh_r;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire hit_hi  = (req.bank == HSCR_BANK_A6) &&
	               (req.addr == HSCR_OFS_HOUR_HIGH);
	wire hit_lo  = (req.bank == HSCR_BANK_A6) &&
	               (req.addr == HSCR_OFS_HOUR_LOW);
	wire hit_rdy = (req.bank == HSCR_BANK_A6) &&
	               (req.addr == HSCR_OFS_READY);
	wire hit_uc  = (req.bank == HSCR_BANK_A2) &&
	               (req.addr == HSCR_OFS_USER_CTRL);
	wire hit_rp  = (req.bank == HSCR_BANK_A2) &&
	               (req.addr == HSCR_OFS_RST_PULSE);
	wire wr_rdy  = req.wr && hit_rdy;
	wire wr_uc   = req.wr && hit_uc;
	wire wr_rp   = req.wr && hit_rp;
	wire rd_uc   = req.rd && hit_uc;

	// ----------------------------------------------------------------
	// Read images
	// ----------------------------------------------------------------
	wire [7:0] img_hi  = {hour_corrupt,                        // [R1]
	                      hour_count[14:HSCR_HOUR_SPLIT]};     // [R2] [R17]
	wire [7:0] img_lo  = hour_count[HSCR_HOUR_SPLIT-1:0];      // [R17]
	wire [7:0] img_rdy = {ready_r, {HSCR_READY_LSB{1'b0}}};    // [R5]
	// Bit 7 has no storage and reads zero
	wire [7:0] img_uc  = {1'b0, mask_r, flag_r, ie_r,          // [R15]
	                      psel_r, msel_r};
	wire [7:0] img_rp  = {5'h00, pulse_r};                     // [R16]

	assign rd_data_nxt = !req.rd ? rd_data_r :
	                     hit_hi  ? img_hi :
	                     hit_lo  ? img_lo :
	                     hit_rdy ? img_rdy :
	                     hit_uc  ? img_uc :
	                     hit_rp  ? img_rp : HSCR_RD_ZERO;

	// ----------------------------------------------------------------
	// Data-ready flags: a completing conversion wins over a clear
	// ----------------------------------------------------------------
	wire [4:0] rdy_wval = req.wdata[7:HSCR_READY_LSB];
	assign ready_nxt = ((wr_rdy ? rdy_wval : ready_r) & ~result_read) // [R4]
	                   | conv_done;                                    // [R3]

	// ----------------------------------------------------------------
	// User control
	// ----------------------------------------------------------------
	wire int_raw = ie_r && mask_r && flag_r;              // [R21] [R13]
	wire int_on  = int_raw && !squash_r;                       // [R8] [R11]

	assign mask_nxt = wr_uc ? req.wdata[HSCR_UC_MASK_BIT] : mask_r;
	assign ie_nxt   = wr_uc ? req.wdata[HSCR_UC_IE_BIT] : ie_r;
	assign psel_nxt = wr_uc ?
		req.wdata[HSCR_UC_PSEL_LSB +: HSCR_SEL_W] : psel_r;    // [R6]
	assign msel_nxt = wr_uc ?
		req.wdata[HSCR_UC_MSEL_LSB +: HSCR_SEL_W] : msel_r;    // [R7]
	// Only the power-on reset sets the flag; a read clears it
	assign flag_nxt = rd_uc ? 1'b0 : flag_r;                   // [R12]
	// Writing enable high while the line is low releases it
	assign squash_nxt = (wr_uc && req.wdata[HSCR_UC_IE_BIT] &&
	                     int_on) ? 1'b1 :                      // [R9]
	                    rd_uc ? 1'b0 : squash_r;

	// ----------------------------------------------------------------
	// Reset-pulse field
	// ----------------------------------------------------------------
	logic pulse_drive;
	logic pulse_clear;
	wire  pulse_fire = wr_rp && reset_mode &&                  // [R20]
	                   (req.wdata[2:0] == HSCR_PULSE_FIRE);    // [R18]

	assign pulse_nxt = wr_rp ? req.wdata[2:0] :
	                   (pulse_clear && pulse_r == HSCR_PULSE_FIRE) ?
	                   HSCR_PULSE_RST : pulse_r;               // [R19]

	hscr_pulse_timer #(
		.CLR_CYC    (CLR_CYC)
	) u_pulse (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.fire       (pulse_fire),
		.drive      (pulse_drive),
		.clear_done (pulse_clear)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ready_r  <= HSCR_READY_RST;
			flag_r   <= HSCR_USER_CTRL_RST[HSCR_UC_FLAG_BIT];  // [R10]
			squash_r <= 1'b0;
			pulse_r  <= HSCR_PULSE_RST;
			rd_data_r <= HSCR_RD_ZERO;
		end else begin
			ready_r  <= ready_nxt;
			flag_r   <= flag_nxt;
			squash_r <= squash_nxt;
			pulse_r  <= pulse_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	// Persistent fields reload from storage after reset release
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			nv_load_r <= 1'b1;
			mask_r    <= HSCR_USER_CTRL_RST[HSCR_UC_MASK_BIT];
			ie_r      <= HSCR_USER_CTRL_RST[HSCR_UC_IE_BIT];
			psel_r    <= HSCR_USER_CTRL_RST[HSCR_UC_PSEL_LSB +: HSCR_SEL_W];
			msel_r    <= HSCR_USER_CTRL_RST[HSCR_UC_MSEL_LSB +: HSCR_SEL_W];
		end else if (nv_load_r) begin
			nv_load_r <= 1'b0;                                 // [R14]
			mask_r    <= nv_user_ctrl[HSCR_UC_MASK_BIT];
			ie_r      <= nv_user_ctrl[HSCR_UC_IE_BIT];
			psel_r    <= nv_user_ctrl[HSCR_UC_PSEL_LSB +: HSCR_SEL_W];
			msel_r    <= nv_user_ctrl[HSCR_UC_MSEL_LSB +: HSCR_SEL_W];
		end else begin
			mask_r    <= mask_nxt;
			ie_r      <= ie_nxt;
			psel_r    <= psel_nxt;
			msel_r    <= msel_nxt;
		end
	end

	// Write-through of persistent fields to storage
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			nv_wr_r    <= 1'b0;
			nv_wdata_r <= HSCR_RD_ZERO;
		end else begin
			nv_wr_r    <= wr_uc && !nv_load_r;                 // [R14]
			if (wr_uc && !nv_load_r)
				nv_wdata_r <= {1'b0, req.wdata[6], 1'b0,
				               req.wdata[4:0]};                // [R15]
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			poh_r <= 3'h0;
			moh_r <= 3'h0;
		end else begin
			poh_r <= sel_decode(psel_nxt);                     // [R6]
			moh_r <= sel_decode(msel_nxt);                     // [R7]
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rd_data                    = rd_data_r;
	assign nv_wr                      = nv_wr_r;
	assign nv_wdata                   = nv_wdata_r;
	assign power_setpoint_select      = psel_r;
	assign modulation_setpoint_select = msel_r;
	assign power_setpoint_onehot      = poh_r;
	assign modulation_setpoint_onehot = moh_r;
	assign int_n_o                    = 1'b0;
	assign int_n_oe                   = int_on;                // [R21]
	assign general_output_pin_o       = 1'b0;
	assign general_output_pin_oe      = pulse_drive;           // [R18]

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_uc_read;
		rd_uc;
	endsequence
	sequence s_released;
		!int_n_oe && !flag_r;
	endsequence

	chk_irq_gate_enable: assert property ( // [R8]
		!ie_r |-> !int_n_oe)
		else $error("interrupt asserted with enable clear");
	chk_irq_cause_and: assert property ( // [R21]
		int_n_oe |-> ie_r && mask_r && flag_r)
		else $error("interrupt asserted without cause");
	chk_read_clears_flag: assert property ( // [R12]
		s_uc_read |=> s_released)
		else $error("user control read left flag or interrupt");
	chk_mask_late_irq: assert property ( // [R13]
		(wr_uc && req.wdata[HSCR_UC_MASK_BIT] && !int_n_oe &&
		 req.wdata[HSCR_UC_IE_BIT] && flag_r && !squash_r && !nv_load_r)
		|=> int_n_oe && flag_r)
		else $error("late mask did not raise interrupt");
	chk_enable_release: assert property ( // [R9]
		(wr_uc && req.wdata[HSCR_UC_IE_BIT] && int_n_oe && !rd_uc)
		|=> !int_n_oe)
		else $error("enable write did not release interrupt");
	chk_ready_set_wins: assert property ( // [R3]
		(conv_done != 5'h00) |=> ((ready_r & $past(conv_done)) ==
		                          $past(conv_done)))
		else $error("conversion did not set ready flag");
	chk_ready_read_clear: assert property ( // [R4]
		(!wr_rdy && result_read != 5'h00) |=>
		((ready_r & $past(result_read) & ~$past(conv_done)) == 5'h00))
		else $error("result read did not clear ready flag");
	chk_hour_high_read: assert property ( // [R1]
		(req.rd && hit_hi) |=>
		rd_data == {$past(hour_corrupt), $past(hour_count[14:8])})
		else $error("hour high byte read mismatch");
	chk_pulse_reserved: assert property ( // [R16]
		(req.rd && hit_rp) |=> rd_data[7:3] == 5'h00)
		else $error("reset-pulse reserved bits not zero");
	chk_fire_drives_pin: assert property ( // [R18]
		pulse_fire && (u_pulse.st_r == HSCR_IDLE) |=> general_output_pin_oe)
		else $error("fire did not drive general output");
	chk_no_mode_no_pin: assert property ( // [R20]
		(wr_rp && !reset_mode && !pulse_drive &&
		 $past(!pulse_drive)) |=> !general_output_pin_oe)
		else $error("reset-pulse field acted outside reset mode");

endmodule

// *** verif/hscr_host_model.sv ***
// Host bus master and persistent storage model facing the register bank
`timescale 1ns/100ps
module hscr_host_model
	import hscr_pkg::*;
(
	// Clock
	input  wire logic       core_clk,
	// Register access
	output hscr_req_t       req,
	input  wire logic [7:0] rd_data,
	// Persistent storage
	input  wire logic       nv_wr,
	input  wire logic [7:0] nv_wdata,
	output logic [7:0]      nv_user_ctrl
);
	initial begin
		req = '0;
		nv_user_ctrl = 8'h00;
	end

	// Image survives reset; only a store strobe changes it
	always @(posedge core_clk) begin
		if (nv_wr) begin
			nv_user_ctrl <= nv_wdata;
		end
	end

	// One access; idle address and data show the inverse of the last value
	task automatic access(input logic w, input logic b, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		logic [7:0] dd;
		dd = (a == HSCR_OFS_USER_CTRL) ? {1'b0, d[6:0]} : d;
		@(posedge core_clk);
		#1;
		req = '{wr: w, rd: !w, bank: b, addr: a, wdata: dd};
		@(posedge core_clk);
		#1;
		q = rd_data;
		req = '{wr: 1'b0, rd: 1'b0, bank: !b, addr: ~a, wdata: ~dd};
	endtask
endmodule

// *** verif/test_host_status_control_regs.sv ***
// Self-checking bench for the host status and control register bank
`timescale 1ns/100ps
module test_host_status_control_regs
	import hscr_pkg::*;
;
	localparam int CLR_CYC = 20;

	logic        core_clk;
	logic        nrst;
	hscr_req_t   req;
	logic [7:0]  rd_data;
	logic [7:0]  nv_user_ctrl;
	logic [7:0]  nv_wdata;
	logic [7:0]  q;
	logic [4:0]  conv_done;
	logic [4:0]  result_read;
	logic [14:0] hour_count;
	logic        hour_corrupt;
	logic        nv_wr;
	logic        reset_mode;
	logic [1:0]  psel;
	logic [1:0]  msel;
	logic [2:0]  p1h;
	logic [2:0]  m1h;
	logic        int_oe;
	logic        int_o;
	logic        gpo_o;
	logic        gpo_oe;
	int          num_errors;
	int          samples_checked;

	hscr_regs #(.CLR_CYC(CLR_CYC)) dut (
		.core_clk(core_clk), .nrst(nrst), .req(req), .rd_data(rd_data),
		.conv_done(conv_done), .result_read(result_read),
		.hour_count(hour_count), .hour_corrupt(hour_corrupt),
		.nv_user_ctrl(nv_user_ctrl), .nv_wr(nv_wr), .nv_wdata(nv_wdata),
		.reset_mode(reset_mode), .power_setpoint_select(psel),
		.modulation_setpoint_select(msel), .power_setpoint_onehot(p1h),
		.modulation_setpoint_onehot(m1h), .int_n_o(int_o), .int_n_oe(int_oe),
		.general_output_pin_o(gpo_o), .general_output_pin_oe(gpo_oe));

	hscr_host_model host (
		.core_clk(core_clk), .req(req), .rd_data(rd_data), .nv_wr(nv_wr),
		.nv_wdata(nv_wdata), .nv_user_ctrl(nv_user_ctrl));

	always #20 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [14:0] got, input logic [14:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic b, input logic [7:0] a);
		host.access(1'b0, b, a, 8'h00, q);
	endtask

	task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] junk;
		host.access(1'b1, b, a, d, junk);
	endtask

	task automatic pulse(input logic [4:0] c, input logic [4:0] r);
		@(posedge core_clk);
		#1;
		conv_done = c;
		result_read = r;
		@(posedge core_clk);
		#1;
		conv_done = 5'h00;
		result_read = 5'h00;
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		#1;
		nrst = 1'b0;
		repeat (16) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		repeat (3) @(posedge core_clk);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_vals();
		rd(HSCR_BANK_A2, HSCR_OFS_USER_CTRL);
		check(q, 8'h20);
		rd(HSCR_BANK_A2, HSCR_OFS_USER_CTRL);
		check(q, 8'h00);
		rd(HSCR_BANK_A2, HSCR_OFS_RST_PULSE);
		check(q, 8'h00);
		rd(HSCR_BANK_A6, HSCR_OFS_READY);
		check(q, 8'h00);
		rd(HSCR_BANK_A6, HSCR_OFS_HOUR_HIGH);
		check(q, 8'h00);
	endtask

	task automatic t_hour();
		hour_count = 15'h5A3C;
		hour_corrupt = 1'b1;
		rd(HSCR_BANK_A6, HSCR_OFS_HOUR_HIGH);
		check(q, 8'hDA);
		rd(HSCR_BANK_A6, HSCR_OFS_HOUR_LOW);
		check(q, 8'h3C);
		hour_corrupt = 1'b0;
		rd(HSCR_BANK_A6, HSCR_OFS_HOUR_HIGH);
		check(q, 8'h5A);
	endtask

	task automatic t_ready();
		pulse(5'h1F, 5'h00);
		rd(HSCR_BANK_A6, HSCR_OFS_READY);
		check(q, 8'hF8);
		pulse(5'h00, 5'h10);
		rd(HSCR_BANK_A6, HSCR_OFS_READY);
		check(q, 8'h78);
		pulse(5'h00, 5'h0F);
		pulse(5'h02, 5'h00);
		rd(HSCR_BANK_A6, HSCR_OFS_READY);
		check(q, 8'h10);
		pulse(5'h01, 5'h01);
		rd(HSCR_BANK_A6, HSCR_OFS_READY);
		check(q, 8'h18);
		wr(HSCR_BANK_A6, HSCR_OFS_READY, 8'h8F);
		rd(HSCR_BANK_A6, HSCR_OFS_READY);
		check(q, 8'h88);
	endtask

	task automatic t_select();
		logic [1:0] p;
		logic [1:0] m;
		for (int c = 0; c < 4; c++) begin
			p = c[1:0];
			m = 2'h3 - p;
			wr(HSCR_BANK_A2, HSCR_OFS_USER_CTRL, {4'h0, p, m});
			check(psel, p);
			check(msel, m);
			check(p1h, (p == 2'h3) ? 3'h0 : 3'h1 << p);
			check(m1h, (m == 2'h3) ? 3'h0 : 3'h1 << m);
			@(posedge core_clk);
			#1;
			check(nv_user_ctrl, {4'h0, p, m});
		end
		rd(HSCR_BANK_A2, HSCR_OFS_USER_CTRL);
		check(q, 8'h0C);
	endtask

	task automatic t_irq();
		wr(HSCR_BANK_A2, HSCR_OFS_USER_CTRL, 8'h40);
		do_reset();
		check(int_oe, 1'b0);
		wr(HSCR_BANK_A2, HSCR_OFS_USER_CTRL, 8'h50);
		check(int_oe, 1'b1);
		check(int_o, 1'b0);
		wr(HSCR_BANK_A2, HSCR_OFS_USER_CTRL, 8'h50);
		check(int_oe, 1'b0);
		rd(HSCR_BANK_A2, HSCR_OFS_USER_CTRL);
		check(q, 8'h70);
		rd(HSCR_BANK_A2, HSCR_OFS_USER_CTRL);
		check(q, 8'h50);
		do_reset();
		check(int_oe, 1'b1);
		rd(HSCR_BANK_A2, HSCR_OFS_USER_CTRL);
		check(q, 8'h70);
		check(int_oe, 1'b0);
		wr(HSCR_BANK_A2, HSCR_OFS_USER_CTRL, 8'h00);
	endtask

	task automatic t_pulse();
		int n;
		wr(HSCR_BANK_A2, HSCR_OFS_RST_PULSE, 8'h07);
		repeat (4) @(posedge core_clk);
		#1;
		check(gpo_oe, 1'b0);
		wr(HSCR_BANK_A2, HSCR_OFS_RST_PULSE, 8'h00);
		reset_mode = 1'b1;
		wr(HSCR_BANK_A2, HSCR_OFS_RST_PULSE, 8'hFF);
		check(gpo_oe, 1'b1);
		check(gpo_o, 1'b0);
		n = 0;
		while (gpo_oe === 1'b1 && n < 4000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(n, HSCR_PULSE_CYC);
		rd(HSCR_BANK_A2, HSCR_OFS_RST_PULSE);
		check(q, 8'h07);
		repeat (CLR_CYC + 5) @(posedge core_clk);
		rd(HSCR_BANK_A2, HSCR_OFS_RST_PULSE);
		check(q, 8'h00);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#(40 * 12000);
		num_errors++;
		test_done();
	end

	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		conv_done = 5'h00;
		result_read = 5'h00;
		hour_count = 15'h0000;
		hour_corrupt = 1'b0;
		reset_mode = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		do_reset();
		t_reset_vals();
		t_hour();
		t_ready();
		t_select();
		t_irq();
		t_pulse();
		test_done();
	end
endmodule
